//--- rtl/isv_controller.sv
`default_nettype none
module isv_controller
   import isv_pkg::*;
(
   input  wire logic                clock_i,
   input  wire logic                rst_i,
   input  wire logic                hw_standby_i,
   input  wire logic                sw_standby_i,
   input  wire logic                nmi_i,
   input  wire logic                nonmaskable_edge_select_i,
   input  wire logic [NUM_PINS-1:0] pin_request_n_i,
   input  wire logic [NUM_PINS-1:0] pin_sense_control_i,
   input  wire logic [NUM_PINS-1:0] pin_request_enable_i,
   input  wire logic                flags_read_i,
   input  wire logic                flags_write_i,
   input  wire logic [NUM_PINS-1:0] flags_wdata_i,
   input  wire logic [7:0]          priority_register_a_i,
   input  wire logic [7:0]          priority_register_b_i,
   input  wire logic [NUM_INT-1:0]  internal_request_i,
   input  wire logic [NUM_INT-1:0]  dma_route_i,
   input  wire logic                core_mask_i,
   input  wire logic                user_mask_bit_i,
   input  wire logic                user_mask_enable_i,
   input  wire logic                take_i,
   input  wire logic [7:0]          take_vector_i,
   output logic [NUM_PINS-1:0]      pin_request_flags_o,
   output logic                     irq_pending_o,
   output logic [7:0]               irq_vector_o,
   output logic [15:0]              irq_address_o,
   output logic                     irq_level_o,
   output logic                     wake_o
);

   logic                nmi_prev;
   logic                nmi_primed;
   logic                nmi_edge;
   logic                nmi_flag;
   logic [NUM_PINS-1:0] pin_flags;
   logic [NUM_PINS-1:0] pin_taken;
   logic [15:0]         prio_bits;
   logic [NUM_SRC-1:0]  src_req;
   logic [NUM_SRC-1:0]  src_high;
   logic [NUM_SRC-1:0]  src_ok;
   logic [7:0]          src_vector [NUM_SRC];
   logic                pick_found;
   logic [IDX_W-1:0]    pick_idx;
   logic                pick_high;
   logic                any_high_ok;
   logic [7:0]          next_vector;

   assign prio_bits = {priority_register_a_i, priority_register_b_i};

   // non-maskable edge detection
   assign nmi_edge = nmi_primed && ((nonmaskable_edge_select_i == NMI_EDGE_RISING)
                                    ? (!nmi_prev && nmi_i)
                                    : (nmi_prev && !nmi_i));

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         nmi_prev   <= 1'b0;
         nmi_primed <= 1'b0;
      end
      else
      begin
         nmi_prev   <= nmi_i;
         nmi_primed <= !hw_standby_i;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         nmi_flag <= 1'b0;
      else if (hw_standby_i)
         nmi_flag <= 1'b0;
      else if (nmi_edge)
         nmi_flag <= 1'b1;
      else if (take_i && take_vector_i == NMI_VECTOR)
         nmi_flag <= 1'b0;
   end

   // pin inputs are read straight from the pad, so port direction does not matter
   generate
      for (genvar p = 0; p < NUM_PINS; p++)
      begin : g_pin
         assign pin_taken[p] = take_i && (take_vector_i == PIN_VECTOR_BASE + 8'(p));
         isv_pin_sense u_sense (
            .clock_i         (clock_i),
            .rst_i           (rst_i),
            .standby_clear_i (hw_standby_i),
            .pin_request_n_i (pin_request_n_i[p]),
            .sense_edge_i    (pin_sense_control_i[p]),
            .flags_read_i    (flags_read_i),
            .flags_write_i   (flags_write_i),
            .wdata_bit_i     (flags_wdata_i[p]),
            .taken_i         (pin_taken[p]),
            .flag_o          (pin_flags[p])
         );
         assign src_req[1+p]    = pin_flags[p] && pin_request_enable_i[p];
         assign src_high[1+p]   = prio_bits[PIN_PRIO_BIT[p]];
         assign src_vector[1+p] = PIN_VECTOR_BASE + 8'(p);
      end
      for (genvar s = 0; s < NUM_INT; s++)
      begin : g_int
         // a request steered to the dma engine never reaches the arbiter
         assign src_req[1+NUM_PINS+s]    = internal_request_i[s]
                                           && !(dma_route_i[s] && DMA_CAPABLE[s]);
         assign src_high[1+NUM_PINS+s]   = prio_bits[INT_PRIO_BIT[s]];
         assign src_vector[1+NUM_PINS+s] = INT_VECTOR[s];
      end
   endgenerate

   assign src_req[0]    = nmi_flag;
   assign src_high[0]   = 1'b1;
   assign src_vector[0] = NMI_VECTOR;

   // core masking: level 1 stays open under the mask bit unless the user mask also closes it
   always_comb
   begin
      src_ok = '0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (i == 0)
            src_ok[i] = src_req[i];
         else
            src_ok[i] = src_req[i] && (!core_mask_i
                        || (!user_mask_enable_i && !user_mask_bit_i && src_high[i]));
      end
   end

   isv_priority_pick #(
      .N (NUM_SRC)
   ) u_pick (
      .req_i   (src_ok),
      .high_i  (src_high),
      .found_o (pick_found),
      .idx_o   (pick_idx),
      .high_o  (pick_high)
   );

   assign any_high_ok = |(src_ok & src_high);
   assign next_vector = src_vector[pick_idx];

   // the chosen request is re-evaluated each cycle; losers stay in their flags
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_pending_o <= 1'b0;
         irq_vector_o  <= VECTOR_RESET;
         irq_address_o <= ADDRESS_RESET;
         irq_level_o   <= 1'b0;
      end
      else if (hw_standby_i)
      begin
         irq_pending_o <= 1'b0;
         irq_vector_o  <= VECTOR_RESET;
         irq_address_o <= ADDRESS_RESET;
         irq_level_o   <= 1'b0;
      end
      else
      begin
         irq_pending_o <= pick_found;
         irq_vector_o  <= pick_found ? next_vector : VECTOR_RESET;
         irq_address_o <= pick_found ? {6'h00, next_vector, 2'b00} : ADDRESS_RESET;
         irq_level_o   <= pick_found && pick_high;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         wake_o <= 1'b0;
      else
         wake_o <= sw_standby_i && !hw_standby_i
                   && (nmi_flag || |(pin_flags & pin_request_enable_i & WAKE_PINS));
   end

   assign pin_request_flags_o = pin_flags;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_nmi_edge_seen;
      nmi_primed && !hw_standby_i && nonmaskable_edge_select_i && !nmi_prev && nmi_i;
   endsequence

   sequence s_pin0_fall;
      !hw_standby_i && pin_sense_control_i[0] && pin_request_n_i[0] ##1
      !hw_standby_i && pin_sense_control_i[0] && !pin_request_n_i[0];
   endsequence

   AST_NMI_RISE_SETS: assert property (s_nmi_edge_seen |=> nmi_flag)
      else $error("rising edge on non-maskable input did not set its flag");

   AST_NMI_WINS: assert property (nmi_flag && !hw_standby_i
                                  |=> irq_pending_o && irq_vector_o == NMI_VECTOR
                                      && irq_address_o == NMI_ENTRY_ADDR)
      else $error("pending non-maskable request was not presented first");

   AST_ADDR_TIMES_FOUR: assert property (irq_pending_o
                                  |-> irq_address_o == {6'h00, irq_vector_o, 2'b00})
      else $error("entry address is not four times the vector");

   AST_NO_RESERVED: assert property (irq_pending_o |-> !(irq_vector_o inside
                                  {8'd18, 8'd19, 8'd22, 8'd23, 8'd27, 8'd31, 8'd35, 8'd39,
                                   8'd43, 8'd48, 8'd49, 8'd50, 8'd51}))
      else $error("reserved vector presented");

   AST_PIN_LEVEL_SET: assert property (!hw_standby_i && !pin_sense_control_i[1]
                                       && !pin_request_n_i[1] |=> pin_flags[1])
      else $error("low level did not set pin flag");

   AST_PIN_EDGE_SET: assert property (s_pin0_fall |=> pin_flags[0])
      else $error("falling edge did not set pin flag");

   AST_STANDBY_CLEARS: assert property (hw_standby_i
                                  |=> pin_flags == FLAGS_RESET && !irq_pending_o && !nmi_flag)
      else $error("hardware standby did not clear state");

   AST_HIGH_FIRST: assert property (irq_pending_o && !irq_level_o
                                    |-> !$past(any_high_ok) && !$past(hw_standby_i))
      else $error("low level presented while a high level request waited");

   AST_PIN_RANGE: assert property (irq_pending_o && irq_vector_o >= PIN_VECTOR_BASE
                                   && irq_vector_o < PIN_VECTOR_BASE + 8'(NUM_PINS)
                                   |-> irq_address_o >= PIN_ENTRY_FIRST
                                       && irq_address_o <= PIN_ENTRY_LAST)
      else $error("pin vector outside its entry range");

   AST_DMA_HELD_BACK: assert property ($past(dma_route_i[2])
                                       |-> !(irq_pending_o && irq_vector_o == INT_VECTOR[2]))
      else $error("dma routed request reached the core");

endmodule : isv_controller
`default_nettype wire

//--- pkg/isv_pkg.sv
`default_nettype none
package isv_pkg;

   localparam int NUM_PINS = 6;
   localparam int NUM_INT  = 30;
   localparam int NUM_SRC  = 1 + NUM_PINS + NUM_INT;
   localparam int IDX_W    = 6;

   // vector numbers and their table entries
   localparam logic [7:0]  NMI_VECTOR      = 8'h07;
   localparam logic [7:0]  PIN_VECTOR_BASE = 8'h0C;
   localparam int          ADDR_SHIFT      = 2;
   localparam logic [15:0] NMI_ENTRY_ADDR  = 16'h001C;
   localparam logic [15:0] PIN_ENTRY_FIRST = 16'h0030;
   localparam logic [15:0] PIN_ENTRY_LAST  = 16'h0047;

   // edge select: 0 = falling edge, 1 = rising edge on the non-maskable input
   localparam logic NMI_EDGE_RISING = 1'b1;
   // sense select: 0 = low level, 1 = falling edge
   localparam logic SENSE_EDGE      = 1'b1;

   // reset values
   localparam logic [NUM_PINS-1:0] FLAGS_RESET   = 6'h00;
   localparam logic [7:0]          VECTOR_RESET  = 8'h00;
   localparam logic [15:0]         ADDRESS_RESET = 16'h0000;

   // only the non-maskable input and pins 0..2 may leave software standby
   localparam logic [NUM_PINS-1:0] WAKE_PINS = 6'h07;

   // internal sources in ascending vector order:
   // 0 watchdog, 1 refresh, 2..16 timer 0..4, 17..20 dma, 21..28 serial 0/1, 29 converter
   localparam logic [7:0] INT_VECTOR [NUM_INT] = '{
      8'h14, 8'h15,
      8'h18, 8'h19, 8'h1A, 8'h1C, 8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22,
      8'h24, 8'h25, 8'h26, 8'h28, 8'h29, 8'h2A,
      8'h2C, 8'h2D, 8'h2E, 8'h2F,
      8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B,
      8'h3C};

   // index into {priority_register_a, priority_register_b}: a bit k -> 8+k, b bit k -> k
   localparam logic [3:0] INT_PRIO_BIT [NUM_INT] = '{
      4'hB, 4'hB,
      4'hA, 4'hA, 4'hA, 4'h9, 4'h9, 4'h9, 4'h8, 4'h8, 4'h8,
      4'h7, 4'h7, 4'h7, 4'h6, 4'h6, 4'h6,
      4'h5, 4'h5, 4'h5, 4'h5,
      4'h3, 4'h3, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h2,
      4'h1};
   localparam logic [3:0] PIN_PRIO_BIT [NUM_PINS] = '{4'hF, 4'hE, 4'hD, 4'hD, 4'hC, 4'hC};

   // timer and serial sources are the ones that may be routed to the dma engine
   localparam logic [NUM_INT-1:0] DMA_CAPABLE = 30'h1FE1FFFC;

endpackage : isv_pkg
`default_nettype wire

//--- rtl/isv_pin_sense.sv
`default_nettype none
module isv_pin_sense
   import isv_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic standby_clear_i,
   input  wire logic pin_request_n_i,
   input  wire logic sense_edge_i,
   input  wire logic flags_read_i,
   input  wire logic flags_write_i,
   input  wire logic wdata_bit_i,
   input  wire logic taken_i,
   output logic      flag_o
);

   logic prev_pin;
   logic primed;
   logic read_one;
   logic set_cond;
   logic clr_cond;

   // primed stops a pin held low through reset from looking like a fresh edge
   assign set_cond = (sense_edge_i != SENSE_EDGE) ? !pin_request_n_i
                   : (primed && prev_pin && !pin_request_n_i);
   assign clr_cond = (flags_write_i && read_one && !wdata_bit_i)
                   || (taken_i && (sense_edge_i == SENSE_EDGE || pin_request_n_i));

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prev_pin <= 1'b1;
         primed   <= 1'b0;
      end
      else
      begin
         prev_pin <= pin_request_n_i;
         primed   <= !standby_clear_i;
      end
   end

   // a write of 0 only clears a flag that software has seen as 1
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         read_one <= 1'b0;
      else if (standby_clear_i)
         read_one <= 1'b0;
      else if (flags_read_i)
         read_one <= flag_o;
      else if (flags_write_i)
         read_one <= 1'b0;
   end

   // set wins over clear so no event is lost
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         flag_o <= 1'b0;
      else if (standby_clear_i)
         flag_o <= 1'b0;
      else if (set_cond)
         flag_o <= 1'b1;
      else if (clr_cond)
         flag_o <= 1'b0;
   end

endmodule : isv_pin_sense
`default_nettype wire

//--- rtl/isv_priority_pick.sv
`default_nettype none
module isv_priority_pick
   import isv_pkg::*;
#(
   parameter int N = NUM_SRC
)
(
   input  wire logic [N-1:0]     req_i,
   input  wire logic [N-1:0]     high_i,
   output logic                  found_o,
   output logic [IDX_W-1:0]      idx_o,
   output logic                  high_o
);

   logic             any_hi;
   logic             any_lo;
   logic [IDX_W-1:0] idx_hi;
   logic [IDX_W-1:0] idx_lo;

   // scanning downward leaves the smallest index, i.e. the smallest vector
   always_comb
   begin
      any_hi = 1'b0;
      any_lo = 1'b0;
      idx_hi = '0;
      idx_lo = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req_i[i] && high_i[i])
         begin
            any_hi = 1'b1;
            idx_hi = IDX_W'(i);
         end
         if (req_i[i])
         begin
            any_lo = 1'b1;
            idx_lo = IDX_W'(i);
         end
      end
   end

   assign found_o = any_lo;
   assign high_o  = any_hi;
   assign idx_o   = any_hi ? idx_hi : idx_lo;

endmodule : isv_priority_pick
`default_nettype wire

//--- sim/isv_core_model.sv
`default_nettype none
module isv_core_model
   import isv_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic [3:0] delay_i,
   input  wire logic       irq_pending_i,
   input  wire logic [7:0] irq_vector_i,
   output logic            take_o,
   output logic [7:0]      take_vector_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_count;
   logic [1:0] cool;
   // cool-off after a take: the pending output drops late, a hasty core would take twice
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         take_o <= 1'b0;
         take_vector_o <= 8'h00;
         wait_count <= 4'h0;
         cool <= 2'h0;
      end
      else
      begin
         take_o <= 1'b0;
         take_vector_o <= ~take_vector_o;
         if (cool != 2'h0)
            cool <= cool - 2'h1;
         else if (run_i && irq_pending_i)
         begin
            if (wait_count >= delay_i)
            begin
               take_o <= 1'b1;
               take_vector_o <= irq_vector_i;
               wait_count <= 4'h0;
               cool <= 2'h3;
            end
            else
               wait_count <= wait_count + 4'h1;
         end
         else
            wait_count <= 4'h0;
      end
   end
endmodule : isv_core_model
`default_nettype wire

//--- sim/isv_controller_tb_top.sv
`default_nettype none
module isv_controller_tb_top
   import isv_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock_i = 1'b0, rst_i = 1'b1, hw_standby_i = 1'b0, sw_standby_i = 1'b0, nmi_i = 1'b0;
   logic        nonmaskable_edge_select_i = 1'b0, flags_read_i = 1'b0, flags_write_i = 1'b0, run = 1'b0;
   logic        core_mask_i = 1'b0, user_mask_bit_i = 1'b0, user_mask_enable_i = 1'b1;
   logic        take_i, lvl, wake, pend;
   logic [5:0]  pin_n = 6'h3F, sense = 6'h00, pen = 6'h00, flags_wdata_i = 6'h00, flags;
   logic [7:0]  pra = 8'h00, prb = 8'h00, take_vector_i, vec, exp_v;
   logic [29:0] ireq = 30'h0, route = 30'h0;
   logic [15:0] addr, prev_addr;
   logic [3:0]  dly = 4'h0;
   logic [7:0]  expq[$];
   int          mismatches = 0, samples_checked = 0;

   isv_controller dut
   (
      .clock_i, .rst_i, .hw_standby_i, .sw_standby_i, .nmi_i, .nonmaskable_edge_select_i,
      .pin_request_n_i(pin_n), .pin_sense_control_i(sense), .pin_request_enable_i(pen),
      .flags_read_i, .flags_write_i, .flags_wdata_i,
      .priority_register_a_i(pra), .priority_register_b_i(prb),
      .internal_request_i(ireq), .dma_route_i(route),
      .core_mask_i, .user_mask_bit_i, .user_mask_enable_i, .take_i, .take_vector_i,
      .pin_request_flags_o(flags), .irq_pending_o(pend), .irq_vector_o(vec),
      .irq_address_o(addr), .irq_level_o(lvl), .wake_o(wake)
   );
   isv_core_model core
   (
      .clock_i, .rst_i, .run_i(run), .delay_i(dly), .irq_pending_i(pend), .irq_vector_i(vec),
      .take_o(take_i), .take_vector_o(take_vector_i)
   );

   initial
      forever #20 clock_i = ~clock_i;

   task automatic step(int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : step

   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask : pulse

   task automatic check(string name, logic [15:0] exp, logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   task automatic drain();
      int i;
      for (i = 0; i < 600 && expq.size() != 0; i++)
         step(1);
      if (i == 600)
      begin
         $display("[FAIL] queue expected 0 seen %0d", expq.size());
         mismatches++;
         complete_run();
      end
      step(4);
   endtask : drain

   // 0: all accepted, 1: only level 1, 2: none but the non-maskable one
   task automatic set_mode(int m);
      core_mask_i = (m != 0);
      user_mask_enable_i = (m == 2);
      user_mask_bit_i = (m == 2) ? 1'($urandom()) : 1'b0;
   endtask : set_mode

   // bits 5..0 are the pins, 35..6 the internal sources; loop order is level 1 then level 0, each in vector order
   task automatic expect_src(logic [35:0] req, int m);
      logic [15:0] p;
      logic        h;
      p = {pra, prb};
      for (int lv = 1; lv >= 0; lv--)
         for (int j = 0; j < 36; j++)
         begin
            h = (j < 6) ? p[PIN_PRIO_BIT[j % 6]] : p[INT_PRIO_BIT[(j + 24) % 30]];
            if (req[j] && h == lv[0] && (m == 0 || (m == 1 && lv == 1)))
               expq.push_back((j < 6) ? PIN_VECTOR_BASE + 8'(j) : INT_VECTOR[(j + 24) % 30]);
         end
   endtask : expect_src

   // the bench stands in for the peripherals: a request drops once its vector is taken
   always @(posedge clock_i)
   begin
      prev_addr <= addr;
      if (take_i === 1'b1)
      begin
         exp_v = (expq.size() != 0) ? expq.pop_front() : 8'hFF;
         check("take_vector", {8'h00, exp_v}, {8'h00, take_vector_i});
         check("entry_address", {8'h00, exp_v} << 2, prev_addr);
         for (int k = 0; k < NUM_INT; k++)
            if (INT_VECTOR[k] == take_vector_i)
               ireq[k] <= 1'b0;
      end
   end

   initial
   begin
      int m;
      logic s;
      void'($urandom(2590));
      step(5);
      rst_i = 1'b0;
      step(1);
      check("flags_reset", 16'h0000, {10'h000, flags});
      check("vector_reset", 16'h0000, {8'h00, vec});
      check("pending_reset", 16'h0000, {15'h0000, pend});
      for (int r = 0; r < 12; r++)
      begin
         m = r % 3;
         set_mode(m);
         pra = (r == 0) ? 8'h00 : 8'($urandom());
         prb = (r == 0) ? 8'h00 : 8'($urandom());
         route = 30'($urandom());
         dly = 4'($urandom_range(3));
         ireq = 30'($urandom());
         expect_src({ireq & ~(route & DMA_CAPABLE), 6'h00}, m);
         run = 1'b1;
         drain();
         check("pending_held", 16'h0000, {15'h0000, pend});
         run = 1'b0;
         ireq = 30'h0;
         step(2);
         $display("internal round %0d done", r);
      end
      set_mode(0);
      pra = 8'($urandom());
      pen = 6'($urandom());
      sense = 6'h3F;
      step(2);
      pin_n = 6'h00;
      expect_src({30'h0, pen}, 0);
      run = 1'b1;
      drain();
      check("edge_flags", {10'h000, ~pen}, {10'h000, flags});
      run = 1'b0;
      pin_n = 6'h3F;
      pulse(flags_write_i);
      step(1);
      check("flags_unread", {10'h000, ~pen}, {10'h000, flags});
      pulse(flags_read_i);
      pulse(flags_write_i);
      step(1);
      check("flags_cleared", 16'h0000, {10'h000, flags});
      $display("edge pin test done");
      sense = 6'h00;
      pen = 6'h00;
      pra = 8'h20;
      pin_n = 6'h2A;
      step(2);
      pin_n = 6'h3F;
      step(1);
      check("level_flags", 16'h0015, {10'h000, flags});
      pen = 6'h14;
      sw_standby_i = 1'b1;
      step(3);
      check("wake", 16'h0001, {15'h0000, wake});
      check("pin_vector", 16'h000E, {8'h00, vec});
      check("pin_address", 16'h0038, addr);
      check("pin_level", 16'h0001, {15'h0000, lvl});
      pen = 6'h10;
      step(3);
      check("wake_pin4", 16'h0000, {15'h0000, wake});
      hw_standby_i = 1'b1;
      step(2);
      hw_standby_i = 1'b0;
      sw_standby_i = 1'b0;
      step(1);
      check("standby_flags", 16'h0000, {10'h000, flags});
      pen = 6'h00;
      $display("level pin test done");
      set_mode(2);
      pra = 8'h08;
      ireq = 30'h1;
      s = 1'($urandom());
      nonmaskable_edge_select_i = s;
      nmi_i = ~s;
      step(3);
      nmi_i = s;
      expq.push_back(NMI_VECTOR);
      run = 1'b1;
      drain();
      nmi_i = ~s;
      step(6);
      check("nmi_wrong_edge", 16'h0000, {15'h0000, pend});
      run = 1'b0;
      ireq = 30'h0;
      $display("nonmaskable test done");
      complete_run();
   end
endmodule : isv_controller_tb_top
`default_nettype wire
